// file: rtl/tlic_pkg.sv
package tlic_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_ENABLE_MAIN = 8'hA8; // Main enable bank
  localparam logic [7:0] ADDR_ENABLE_AUX = 8'hA9; // Secondary enable bank
  localparam logic [7:0] ADDR_LEVEL_SEL = 8'hB8; // Level select bank
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'hC0; // Sticky event status
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hC1; // Event mask
  localparam logic [7:0] ADDR_SVC_STATE = 8'hC2; // Active levels and last winner

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_ENABLE_MAIN = 8'h00;
  localparam logic [7:0] RST_ENABLE_AUX = 8'h00;
  localparam logic [7:0] RST_LEVEL_SEL = 8'h00;
  localparam logic [1:0] RST_IRQ = 2'h0;
  localparam logic [7:0] AUX_WRITE_MASK = 8'h03; // Bits 7..2 reserved

  // ----------------------------------------
  // Main enable bit positions
  // ----------------------------------------
  localparam int BIT_GLOBAL_GATE = 7;
  localparam int BIT_CONVERTER_GATE = 6;
  localparam int BIT_TMR2_GATE = 5;
  localparam int BIT_UART_GATE = 4;
  localparam int BIT_TMR1_GATE = 3;
  localparam int BIT_EXT1_GATE = 2;
  localparam int BIT_TMR0_GATE = 1;
  localparam int BIT_EXT0_GATE = 0;
  // Aux enable bit positions
  localparam int BIT_SUPPLY_MON_GATE = 1;
  localparam int BIT_I2C_SPI_GATE = 0;
  // Level bit positions
  localparam int BIT_I2C_SPI_LEVEL = 7;
  localparam int BIT_CONV_LEVEL = 6;
  localparam int BIT_TMR2_LEVEL = 5;
  localparam int BIT_UART_LEVEL = 4;
  localparam int BIT_TMR1_LEVEL = 3;
  localparam int BIT_EXT1_LEVEL = 2;
  localparam int BIT_TMR0_LEVEL = 1;
  localparam int BIT_EXT0_LEVEL = 0;
  // Status / mask bit positions
  localparam int BIT_EV_TAKEN = 0; // A vector was taken
  localparam int BIT_EV_PREEMPT = 1; // A high request preempted a low routine

  // ----------------------------------------
  // Sources, in polling order (index 0 wins)
  // ----------------------------------------
  localparam int NUM_SRC = 9;
  localparam int SRC_SUPPLY = 0;
  localparam int SRC_EXT0 = 1;
  localparam int SRC_CONV = 2;
  localparam int SRC_TMR0 = 3;
  localparam int SRC_EXT1 = 4;
  localparam int SRC_TMR1 = 5;
  localparam int SRC_I2C_SPI = 6;
  localparam int SRC_UART = 7;
  localparam int SRC_TMR2 = 8;

  // ----------------------------------------
  // Vector addresses per polling index
  // ----------------------------------------
  localparam logic [15:0] VEC_SUPPLY = 16'h0043;
  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_CONV = 16'h0033;
  localparam logic [15:0] VEC_TMR0 = 16'h000B;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_TMR1 = 16'h001B;
  localparam logic [15:0] VEC_I2C_SPI = 16'h003B;
  localparam logic [15:0] VEC_UART = 16'h0023;
  localparam logic [15:0] VEC_TMR2 = 16'h002B;

  // Raw request flags from the peripherals
  typedef struct packed {
    logic supply_mon_req;
    logic ext0_req;
    logic conv_req;
    logic tmr0_ovf;
    logic ext1_req;
    logic tmr1_ovf;
    logic i2c_done;
    logic spi_done;
    logic uart_rx_done;
    logic uart_tx_done;
    logic tmr2_ovf;
    logic tmr2_ext_flag;
  } tlic_flags_s;

  // Request to the core
  typedef struct packed {
    logic valid;
    logic high;
    logic [15:0] vector;
    logic [3:0] source;
  } tlic_req_s;

endpackage

// file: rtl/tlic_arbiter.sv
`timescale 1ns/100ps
// Fixed-order pick of the first set request
module tlic_arbiter #(
  parameter int N = 9
) (
  input wire logic [N-1:0] req, // Requests, index 0 first
  output logic any, // Some request present
  output logic [3:0] idx // Index of the winner
);

  // ----------------------------------------
  // Priority scan
  // ----------------------------------------
  always_comb begin
    any = 1'b0;
    idx = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin // Lower index overrides
        any = 1'b1;
        idx = 4'(i);
      end
    end
  end

endmodule

// file: rtl/tlic_top.sv
// Functional notes
// - Nine sources, each high or low level except the supply monitor, fixed low
// - Global gate bit 7 blocks all sources
// - Main bank holds seven per-source enables
// - Aux bank: supply monitor, I2C/SPI enables
// - Level bank: one priority bit per source except the supply monitor
// - High request preempts running low routine
// - High level served before low level
// - Same level withheld while routine active
// - Fixed polling order within one level
// - Core pushes PC, loads supplied vector
// - Fixed vector address per source
// - Paired flags share one request line
// - Timer 2 external flag still interrupts
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
module tlic_top (
  input wire logic clock, // Core clock, 40 MHz
  input wire logic rst_b, // Async reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after strobe
  input wire tlic_pkg::tlic_flags_s flags, // Peripheral flags
  output tlic_pkg::tlic_req_s core_req, // Request to core
  input wire logic core_ack, // Core takes the request
  input wire logic core_reti, // Core returns from routine
  output logic irq // Level interrupt of own events
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] enable_bank_main; // Main enables
  logic [7:0] enable_bank_aux; // Aux enables
  logic [7:0] level_select_bank; // Level per source
  logic [1:0] irq_status; // Sticky events
  logic [1:0] irq_mask; // Event mask
  logic act_high; // High routine running
  logic act_low; // Low routine running
  logic [3:0] last_src; // Last source taken

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  logic wr_main, wr_aux, wr_lvl, wr_stat, wr_mask;

  // Address match used by every write and read
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  always_comb begin
    wr_main = clk_en && reg_wr && hit(reg_addr, tlic_pkg::ADDR_ENABLE_MAIN);
    wr_aux = clk_en && reg_wr && hit(reg_addr, tlic_pkg::ADDR_ENABLE_AUX);
    wr_lvl = clk_en && reg_wr && hit(reg_addr, tlic_pkg::ADDR_LEVEL_SEL);
    wr_stat = clk_en && reg_wr && hit(reg_addr, tlic_pkg::ADDR_IRQ_STATUS);
    wr_mask = clk_en && reg_wr && hit(reg_addr, tlic_pkg::ADDR_IRQ_MASK);
  end

  // ----------------------------------------
  // Source requests
  // ----------------------------------------
  logic [8:0] raw; // Combined request lines, polling order
  logic [8:0] gate; // Per-source enables, polling order
  logic [8:0] lvl; // Per-source level, polling order
  logic [8:0] eligible; // Enabled and allowed now
  logic [8:0] elig_hi; // Eligible high-level requests
  logic [8:0] elig_lo; // Eligible low-level requests

  // Flag pairs share one line; tmr2_ovf stays low in baud mode upstream
  always_comb begin
    raw[tlic_pkg::SRC_SUPPLY] = flags.supply_mon_req;
    raw[tlic_pkg::SRC_EXT0] = flags.ext0_req;
    raw[tlic_pkg::SRC_CONV] = flags.conv_req;
    raw[tlic_pkg::SRC_TMR0] = flags.tmr0_ovf;
    raw[tlic_pkg::SRC_EXT1] = flags.ext1_req;
    raw[tlic_pkg::SRC_TMR1] = flags.tmr1_ovf;
    raw[tlic_pkg::SRC_I2C_SPI] = flags.i2c_done | flags.spi_done;
    raw[tlic_pkg::SRC_UART] = flags.uart_rx_done | flags.uart_tx_done;
    raw[tlic_pkg::SRC_TMR2] = flags.tmr2_ovf | flags.tmr2_ext_flag;
  end

  // Enable mapping from the two enable banks
  always_comb begin
    gate[tlic_pkg::SRC_SUPPLY] = enable_bank_aux[tlic_pkg::BIT_SUPPLY_MON_GATE];
    gate[tlic_pkg::SRC_I2C_SPI] = enable_bank_aux[tlic_pkg::BIT_I2C_SPI_GATE];
    gate[tlic_pkg::SRC_EXT0] = enable_bank_main[tlic_pkg::BIT_EXT0_GATE];
    gate[tlic_pkg::SRC_CONV] = enable_bank_main[tlic_pkg::BIT_CONVERTER_GATE];
    gate[tlic_pkg::SRC_TMR0] = enable_bank_main[tlic_pkg::BIT_TMR0_GATE];
    gate[tlic_pkg::SRC_EXT1] = enable_bank_main[tlic_pkg::BIT_EXT1_GATE];
    gate[tlic_pkg::SRC_TMR1] = enable_bank_main[tlic_pkg::BIT_TMR1_GATE];
    gate[tlic_pkg::SRC_UART] = enable_bank_main[tlic_pkg::BIT_UART_GATE];
    gate[tlic_pkg::SRC_TMR2] = enable_bank_main[tlic_pkg::BIT_TMR2_GATE];
  end

  // Level mapping; supply monitor has no level bit and stays low
  always_comb begin
    lvl[tlic_pkg::SRC_SUPPLY] = 1'b0;
    lvl[tlic_pkg::SRC_EXT0] = level_select_bank[tlic_pkg::BIT_EXT0_LEVEL];
    lvl[tlic_pkg::SRC_CONV] = level_select_bank[tlic_pkg::BIT_CONV_LEVEL];
    lvl[tlic_pkg::SRC_TMR0] = level_select_bank[tlic_pkg::BIT_TMR0_LEVEL];
    lvl[tlic_pkg::SRC_EXT1] = level_select_bank[tlic_pkg::BIT_EXT1_LEVEL];
    lvl[tlic_pkg::SRC_TMR1] = level_select_bank[tlic_pkg::BIT_TMR1_LEVEL];
    lvl[tlic_pkg::SRC_I2C_SPI] = level_select_bank[tlic_pkg::BIT_I2C_SPI_LEVEL];
    lvl[tlic_pkg::SRC_UART] = level_select_bank[tlic_pkg::BIT_UART_LEVEL];
    lvl[tlic_pkg::SRC_TMR2] = level_select_bank[tlic_pkg::BIT_TMR2_LEVEL];
  end

  // Gating and level split across the nine sources
  genvar g;
  generate
    for (g = 0; g < tlic_pkg::NUM_SRC; g++) begin : g_src
      // Global gate overrides every per-source enable
      assign eligible[g] = raw[g] && gate[g] && enable_bank_main[tlic_pkg::BIT_GLOBAL_GATE];
      // High withheld while a high routine runs
      assign elig_hi[g] = eligible[g] && lvl[g] && !act_high;
      // Low withheld while any routine runs
      assign elig_lo[g] = eligible[g] && !lvl[g] && !act_high && !act_low;
    end
  endgenerate

  // ----------------------------------------
  // Arbitration
  // ----------------------------------------
  logic hi_any, lo_any;
  logic [3:0] hi_idx, lo_idx;

  tlic_arbiter #(.N(tlic_pkg::NUM_SRC)) u_arb_hi (
    .req(elig_hi),
    .any(hi_any),
    .idx(hi_idx)
  );

  tlic_arbiter #(.N(tlic_pkg::NUM_SRC)) u_arb_lo (
    .req(elig_lo),
    .any(lo_any),
    .idx(lo_idx)
  );

  // Vector lookup by polling index
  function automatic logic [15:0] vec_of(input logic [3:0] s);
    unique case (s)
      4'h0: vec_of = tlic_pkg::VEC_SUPPLY;
      4'h1: vec_of = tlic_pkg::VEC_EXT0;
      4'h2: vec_of = tlic_pkg::VEC_CONV;
      4'h3: vec_of = tlic_pkg::VEC_TMR0;
      4'h4: vec_of = tlic_pkg::VEC_EXT1;
      4'h5: vec_of = tlic_pkg::VEC_TMR1;
      4'h6: vec_of = tlic_pkg::VEC_I2C_SPI;
      4'h7: vec_of = tlic_pkg::VEC_UART;
      4'h8: vec_of = tlic_pkg::VEC_TMR2;
      default: vec_of = 16'h0000; // Illegal index
    endcase
  endfunction

  // Winner: high level first, then low
  logic win_high;
  logic [3:0] win_idx;
  always_comb begin
    win_high = hi_any;
    win_idx = hi_any ? hi_idx : lo_idx;
  end

  // ----------------------------------------
  // Request to core
  // ----------------------------------------
  // Registered request, refreshed each enabled cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      core_req <= '0;
    end else if (clk_en) begin
      if (core_ack && core_req.valid) begin // Taken: drop until next compare
        core_req <= '0;
      end else begin
        core_req.valid <= hi_any || lo_any;
        core_req.high <= win_high;
        core_req.vector <= vec_of(win_idx);
        core_req.source <= win_idx;
      end
    end
  end

  // ----------------------------------------
  // Active level tracking
  // ----------------------------------------
  logic take; // Core accepts the presented request
  assign take = clk_en && core_ack && core_req.valid;

  // Set on acceptance, clear on return (innermost level first)
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      act_high <= 1'b0;
      act_low <= 1'b0;
    end else if (clk_en) begin
      if (take) begin
        if (core_req.high) begin
          act_high <= 1'b1;
        end else begin
          act_low <= 1'b1;
        end
      end else if (core_reti) begin
        if (act_high) begin
          act_high <= 1'b0;
        end else begin
          act_low <= 1'b0;
        end
      end
    end
  end

  // Last accepted source, for software view
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      last_src <= 4'h0;
    end else if (take) begin
      last_src <= core_req.source;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Main enable bank
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      enable_bank_main <= tlic_pkg::RST_ENABLE_MAIN;
    end else if (wr_main) begin
      enable_bank_main <= reg_wdata;
    end
  end

  // Aux enable bank, reserved bits held at zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      enable_bank_aux <= tlic_pkg::RST_ENABLE_AUX;
    end else if (wr_aux) begin
      enable_bank_aux <= reg_wdata & tlic_pkg::AUX_WRITE_MASK;
    end
  end

  // Level select bank
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      level_select_bank <= tlic_pkg::RST_LEVEL_SEL;
    end else if (wr_lvl) begin
      level_select_bank <= reg_wdata;
    end
  end

  // ----------------------------------------
  // Own event interrupt
  // ----------------------------------------
  logic [1:0] ev; // Event pulses this cycle
  always_comb begin
    ev = '0;
    ev[tlic_pkg::BIT_EV_TAKEN] = take;
    ev[tlic_pkg::BIT_EV_PREEMPT] = take && core_req.high && act_low;
  end

  // Sticky status: write one clears, a new event wins
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_status <= tlic_pkg::RST_IRQ;
    end else if (clk_en) begin
      irq_status <= (irq_status & ~(wr_stat ? reg_wdata[1:0] : 2'h0)) | ev;
    end
  end

  // Mask register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask <= tlic_pkg::RST_IRQ;
    end else if (wr_mask) begin
      irq_mask <= reg_wdata[1:0];
    end
  end

  // Level output while any unmasked bit set
  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Read data registered; unmapped reads return zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (reg_rd) begin
        if (hit(reg_addr, tlic_pkg::ADDR_ENABLE_MAIN)) begin
          reg_rdata <= enable_bank_main;
        end else if (hit(reg_addr, tlic_pkg::ADDR_ENABLE_AUX)) begin
          reg_rdata <= enable_bank_aux;
        end else if (hit(reg_addr, tlic_pkg::ADDR_LEVEL_SEL)) begin
          reg_rdata <= level_select_bank;
        end else if (hit(reg_addr, tlic_pkg::ADDR_IRQ_STATUS)) begin
          reg_rdata <= {6'h00, irq_status};
        end else if (hit(reg_addr, tlic_pkg::ADDR_IRQ_MASK)) begin
          reg_rdata <= {6'h00, irq_mask};
        end else if (hit(reg_addr, tlic_pkg::ADDR_SVC_STATE)) begin
          reg_rdata <= {2'h0, act_high, act_low, last_src};
        end else begin
          reg_rdata <= 8'h00; // Unmapped
        end
      end else begin
        reg_rdata <= 8'h00; // Data valid only in cycle after strobe
      end
    end
  end

endmodule

// file: tb/tlic_top_asserts.sv
`timescale 1ns/100ps
module tlic_top_asserts (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire tlic_pkg::tlic_flags_s flags,
  input wire tlic_pkg::tlic_req_s core_req,
  input wire logic core_ack,
  input wire logic core_reti,
  input wire logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------
  // Expected vector per polling index
  // ----------------------------------------
  function automatic logic [15:0] vec_of(input logic [3:0] s);
    case (s)
      4'h0: vec_of = 16'h0043;
      4'h1: vec_of = 16'h0003;
      4'h2: vec_of = 16'h0033;
      4'h3: vec_of = 16'h000B;
      4'h4: vec_of = 16'h0013;
      4'h5: vec_of = 16'h001B;
      4'h6: vec_of = 16'h003B;
      4'h7: vec_of = 16'h0023;
      default: vec_of = 16'h002B;
    endcase
  endfunction

  // ----------------------------------------
  // Sequences and properties
  // ----------------------------------------
  sequence s_take;
    clk_en && core_req.valid && core_ack;
  endsequence
  sequence s_main_wr_rd;
    clk_en && reg_wr && reg_addr == 8'hA8 ##1 clk_en && reg_rd && reg_addr == 8'hA8;
  endsequence
  property p_rd_idle;
    clk_en && !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  property p_aux_resv;
    clk_en && reg_rd && reg_addr == 8'hA9 |=> reg_rdata[7:2] == 6'h00;
  endproperty
  property p_main_rw;
    s_main_wr_rd |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  property p_vec;
    core_req.valid |-> core_req.vector == vec_of(core_req.source);
  endproperty
  property p_src_range;
    core_req.valid |-> core_req.source <= 4'h8;
  endproperty
  property p_tmr2_pair;
    core_req.valid && core_req.source == 4'h8 |-> $past(flags.tmr2_ovf || flags.tmr2_ext_flag);
  endproperty
  property p_supply_low;
    core_req.valid && core_req.source == 4'h0 |-> !core_req.high;
  endproperty
  property p_take_clear;
    s_take |=> !core_req.valid;
  endproperty
  property p_irq_fall;
    $fell(irq) |-> $past(reg_wr) && ($past(reg_addr) == 8'hC0 || $past(reg_addr) == 8'hC1);
  endproperty

  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read");
  a_aux_resv: assert property (p_aux_resv) else $error("aux reserved bits not zero");
  a_main_rw: assert property (p_main_rw) else $error("main enable readback wrong");
  a_vec: assert property (p_vec) else $error("vector does not match source");
  a_src_range: assert property (p_src_range) else $error("source index out of range");
  a_tmr2_pair: assert property (p_tmr2_pair) else $error("timer 2 request without flag");
  a_supply_low: assert property (p_supply_low) else $error("supply monitor offered high");
  a_take_clear: assert property (p_take_clear) else $error("request not cleared after ack");
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without status or mask write");
endmodule

bind tlic_top tlic_top_asserts u_chk (.clock(clock), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flags(flags),
  .core_req(core_req), .core_ack(core_ack), .core_reti(core_reti), .irq(irq));

// file: tb/tlic_core_model.sv
`timescale 1ns/100ps
// Processor core side: takes requests, returns from routines
module tlic_core_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire tlic_pkg::tlic_req_s core_req,
  input wire logic [1:0] dly, // Cycles to wait before ack
  input wire logic finish, // Ask for a routine return
  output logic core_ack,
  output logic core_reti,
  output logic taken, // One cycle after a request is taken
  output tlic_pkg::tlic_req_s cap // Request as taken
);
  logic [1:0] cnt; // Ack delay counter

  // ----------------------------------------
  // Ack, capture and return
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      core_ack <= 1'b0;
      core_reti <= 1'b0;
      taken <= 1'b0;
      cap <= '0;
      cnt <= 2'h0;
    end else begin
      taken <= 1'b0;
      core_reti <= finish;
      if (core_ack) begin
        // Ack held one cycle, request taken at that edge
        core_ack <= 1'b0;
        if (core_req.valid) begin
          taken <= 1'b1;
          cap <= core_req;
        end
      end else if (core_req.valid) begin
        // Slow or prompt answer
        if (cnt == dly) begin
          core_ack <= 1'b1;
          cnt <= 2'h0;
        end else begin
          cnt <= cnt + 2'h1;
        end
      end
    end
  end
endmodule

// file: tb/two_level_interrupt_controller_tb.sv
`timescale 1ns/100ps
module two_level_interrupt_controller_tb;
  logic clock, rst_b, clk_en, reg_wr, reg_rd, core_ack, core_reti, irq, finish, taken;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [11:0] fv; // Peripheral flags, supply monitor at MSB
  logic [1:0] dly;
  tlic_pkg::tlic_req_s core_req, cap;
  int err_count, checks;
  logic [15:0] vtab [9] = '{16'h0043, 16'h0003, 16'h0033, 16'h000B, 16'h0013, 16'h001B, 16'h003B,
    16'h0023, 16'h002B};
  int stab [12] = '{8, 8, 7, 7, 6, 6, 5, 4, 3, 2, 1, 0}; // Source of each flag bit

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  tlic_top DUT (.clock(clock), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flags(fv), .core_req(core_req),
    .core_ack(core_ack), .core_reti(core_reti), .irq(irq));
  tlic_core_model u_core (.clock(clock), .rst_b(rst_b), .core_req(core_req), .dly(dly), .finish(finish),
    .core_ack(core_ack), .core_reti(core_reti), .taken(taken), .cap(cap));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (exp !== got) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk("reg_rdata", {8'h00, d}, {8'h00, reg_rdata});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
  endtask
  task automatic setf(input logic [11:0] v);
    @(posedge clock);
    fv <= v;
  endtask
  task automatic ret();
    @(posedge clock);
    finish <= 1'b1;
    @(posedge clock);
    finish <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge clock);
      chk("core_req.valid", 16'h0000, {15'h0000, core_req.valid});
    end
  endtask
  task automatic take(input int s, input logic h);
    int n;
    n = 0;
    while (taken !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    if (taken !== 1'b1) begin
      err_count++;
      $display("[ERR] taken expected 1 seen 0");
      give_verdict();
    end
    chk("source", 16'(s), {12'h000, cap.source});
    chk("vector", vtab[s], cap.vector);
    chk("high", {15'h0000, h}, {15'h0000, cap.high});
    @(negedge clock);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd(8'hA8, 8'h00);
    rd(8'hA9, 8'h00);
    rd(8'hB8, 8'h00);
    wr_rd(8'hA8, 8'hFF);
    wr(8'hA9, 8'hFF);
    rd(8'hA9, 8'h03);
    wr(8'hB8, 8'hA5);
    rd(8'hB8, 8'hA5);
    rd(8'h10, 8'h00);
    wr(8'hB8, 8'h00);
  endtask
  task automatic t_gate();
    wr(8'hA8, 8'h7F);
    setf(12'h400);
    quiet(8);
    wr(8'hA8, 8'h81);
    take(1, 1'b0);
    setf(12'h000);
    ret();
  endtask
  task automatic t_each();
    wr(8'hA8, 8'hFF);
    for (int b = 11; b >= 0; b--) begin
      dly <= 2'(b);
      setf(12'h001 << b);
      take(stab[b], 1'b0);
      setf(12'h000);
      ret();
    end
    dly <= 2'h0;
  endtask
  task automatic t_poll();
    setf(12'hFFF);
    for (int s = 0; s < 9; s++) begin
      take(s, 1'b0);
      @(posedge clock);
      for (int b = 0; b < 12; b++) begin
        if (stab[b] == s) begin
          fv[b] <= 1'b0;
        end
      end
      ret();
    end
  endtask
  task automatic t_prio();
    wr(8'hB8, 8'h08);
    setf(12'h440);
    take(5, 1'b1);
    setf(12'h400);
    ret();
    take(1, 1'b0);
    setf(12'h080);
    quiet(8);
    setf(12'h0C0);
    take(5, 1'b1);
    setf(12'h080);
    ret();
    quiet(4);
    ret();
    take(4, 1'b0);
    setf(12'h000);
    ret();
  endtask
  task automatic t_freeze();
    @(posedge clock);
    clk_en <= 1'b0;
    wr(8'hA8, 8'h00);
    @(posedge clock);
    clk_en <= 1'b1;
    rd(8'hA8, 8'hFF);
    rd(8'hC2, 8'h04);
  endtask
  task automatic t_irq();
    wr(8'hC0, 8'h03);
    wr(8'hC1, 8'h01);
    @(negedge clock);
    chk("irq", 16'h0000, {15'h0000, irq});
    setf(12'h400);
    take(1, 1'b0);
    setf(12'h000);
    ret();
    @(negedge clock);
    chk("irq", 16'h0001, {15'h0000, irq});
    wr(8'hC1, 8'h00);
    @(negedge clock);
    chk("irq", 16'h0000, {15'h0000, irq});
    wr(8'hC1, 8'h01);
    @(negedge clock);
    chk("irq", 16'h0001, {15'h0000, irq});
    wr(8'hC0, 8'h01);
    @(negedge clock);
    chk("irq", 16'h0000, {15'h0000, irq});
  endtask

  // ----------------------------------------
  // Verdict and main sequence
  // ----------------------------------------
  task automatic give_verdict();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    fv = 12'h000;
    finish = 1'b0;
    dly = 2'h0;
    err_count = 0;
    checks = 0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    t_regs();
    t_gate();
    t_each();
    t_poll();
    t_prio();
    t_freeze();
    t_irq();
    give_verdict();
  end
endmodule
